// ### src/ip_address_source_select.v
// Operation
// - Switches 3 and 9 on, 1, 2, 4 off selects the stored mode, addresses from nonvolatile memory.
// - With switch 9 on, switches 5 to 8 are ignored; switch 0 is always ignored.
// - One-time mode with flag clear asks the server and stores address, mask and gateway.
// - After that store the persistent flag is set.
// - One-time mode with flag set loads from nonvolatile memory and skips the server.
// - Any other mode at power-up clears the persistent flag.
// - One-time mode after the flag was cleared asks the server afresh.
// - Switches 4 and 9 on, 1, 2, 3 off selects the one-time mode.
// - Switch 9 off is direct setting; switches 1..8 form the last byte, switch 1 the LSB.
// - In direct setting the upper three bytes and mask/gateway come from the project store.
// - Switches 1 to 9 all off restores the default address set.
// - Switches are sampled once after power-up only.
// - Defaults are 192.168.1.254, mask 255.255.255.0, gateway 192.168.1.1.
// - Switches 1+9 select dynamic server, 2+9 select boot server.
// - Direct last byte 0 and 255 are invalid.
`timescale 1ns/1ps
`include "ip_source_consts.vh"

module ip_address_source_select (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire [9:0]  sw_in,
  // nonvolatile memory: read returns stored set and flag one cycle later on nv_ack_in
  output reg         nv_rd_out,
  output reg         nv_wr_out,
  output reg  [31:0] nv_wr_ip_out,
  output reg  [31:0] nv_wr_mask_out,
  output reg  [31:0] nv_wr_gw_out,
  output reg         nv_flag_wr_out,
  output reg         nv_flag_val_out,
  input  wire        nv_ack_in,
  input  wire [31:0] nv_ip_in,
  input  wire [31:0] nv_mask_in,
  input  wire [31:0] nv_gw_in,
  input  wire        nv_flag_in,
  // address server exchange
  output reg         srv_req_out,
  input  wire        srv_rsp_in,
  input  wire [31:0] srv_ip_in,
  input  wire [31:0] srv_mask_in,
  input  wire [31:0] srv_gw_in,
  // results
  output reg  [2:0]  mode_out,
  output reg  [31:0] ip_out,
  output reg  [31:0] mask_out,
  output reg  [31:0] gw_out,
  output reg         addr_valid_out,
  output reg         cfg_err_out,
  output reg         done_out
);
  localparam ST_SAMPLE = 3'h0;
  localparam ST_NV_WT  = 3'h2;
  localparam ST_SRV    = 3'h3;
  localparam ST_STORE  = 3'h4;
  localparam ST_FLAG   = 3'h5;
  localparam ST_DONE   = 3'h6;

  wire [2:0] dec_mode;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [7:0] last_byte_reg;

  mode_decode u_dec (
    .sw_in    (sw_in),
    .mode_out (dec_mode)
  );

  function byte_ok;
    input [7:0] b;
    begin
      byte_ok = (b >= `LAST_BYTE_MIN) && (b <= `LAST_BYTE_MAX);
    end
  endfunction

  // the one-time dynamic mode is the only one that keeps the flag
  function is_one_time;
    input [2:0] m;
    begin
      is_one_time = (m == `MODE_ONE_TIME);
    end
  endfunction

  // one pass per power-up; nothing leaves ST_DONE until the next reset
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_SAMPLE: begin
        case (dec_mode)
          `MODE_DEFAULT, `MODE_ERROR: begin
            state_next = ST_FLAG;
          end
          `MODE_DYN_SERVER, `MODE_BOOT_SERVER: begin
            state_next = ST_SRV;
          end
          default: begin
            state_next = ST_NV_WT;
          end
        endcase
      end
      ST_NV_WT: begin
        if (nv_ack_in) begin
          if (!is_one_time(mode_out))
            state_next = ST_FLAG;
          else if (nv_flag_in)
            state_next = ST_DONE;
          else
            state_next = ST_SRV;
        end
      end
      ST_SRV: begin
        if (srv_rsp_in)
          state_next = is_one_time(mode_out) ? ST_STORE : ST_FLAG;
      end
      ST_STORE: begin
        state_next = ST_DONE;
      end
      ST_FLAG: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_DONE;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg       <= ST_SAMPLE;
      last_byte_reg   <= `RST_BYTE;
      mode_out        <= `MODE_DEFAULT;
      ip_out          <= `RST_WORD;
      mask_out        <= `RST_WORD;
      gw_out          <= `RST_WORD;
      addr_valid_out  <= 1'b0;
      cfg_err_out     <= 1'b0;
      done_out        <= 1'b0;
      nv_rd_out       <= 1'b0;
      nv_wr_out       <= 1'b0;
      nv_wr_ip_out    <= `RST_WORD;
      nv_wr_mask_out  <= `RST_WORD;
      nv_wr_gw_out    <= `RST_WORD;
      nv_flag_wr_out  <= 1'b0;
      nv_flag_val_out <= 1'b0;
      srv_req_out     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      nv_rd_out      <= 1'b0;
      nv_wr_out      <= 1'b0;
      nv_flag_wr_out <= 1'b0;
      case (state_reg)
        ST_SAMPLE: begin
          // the only cycle the switches are looked at
          mode_out      <= dec_mode;
          last_byte_reg <= sw_in[`SW_BYTE_MSB:`SW_BYTE_LSB];
          case (dec_mode)
            `MODE_DEFAULT: begin
              ip_out         <= `DEF_IP;
              mask_out       <= `DEF_MASK;
              gw_out         <= `DEF_GW;
              addr_valid_out <= 1'b1;
            end
            `MODE_ERROR: begin
              cfg_err_out <= 1'b1;
            end
            `MODE_DYN_SERVER, `MODE_BOOT_SERVER: begin
              srv_req_out <= 1'b1;
            end
            default: begin
              nv_rd_out <= 1'b1;
            end
          endcase
        end
        ST_NV_WT: begin
          if (nv_ack_in) begin
            if (is_one_time(mode_out) && !nv_flag_in) begin
              srv_req_out <= 1'b1;
            end else begin
              mask_out <= nv_mask_in;
              gw_out   <= nv_gw_in;
              if (mode_out == `MODE_DIRECT) begin
                ip_out         <= {nv_ip_in[31:`IP_HI_LSB], last_byte_reg};
                addr_valid_out <= byte_ok(last_byte_reg);
                cfg_err_out    <= !byte_ok(last_byte_reg);
              end else begin
                ip_out         <= nv_ip_in;
                addr_valid_out <= 1'b1;
              end
            end
          end
        end
        ST_SRV: begin
          if (srv_rsp_in) begin
            srv_req_out    <= 1'b0;
            ip_out         <= srv_ip_in;
            mask_out       <= srv_mask_in;
            gw_out         <= srv_gw_in;
            addr_valid_out <= 1'b1;
            if (is_one_time(mode_out)) begin
              nv_wr_out      <= 1'b1;
              nv_wr_ip_out   <= srv_ip_in;
              nv_wr_mask_out <= srv_mask_in;
              nv_wr_gw_out   <= srv_gw_in;
            end
          end
        end
        ST_STORE: begin
          // flag only after the address set is written
          nv_flag_wr_out  <= 1'b1;
          nv_flag_val_out <= 1'b1;
        end
        ST_FLAG: begin
          nv_flag_wr_out  <= 1'b1;
          nv_flag_val_out <= 1'b0;
        end
        ST_DONE: begin
          done_out <= 1'b1;
        end
        default: done_out <= 1'b0;
      endcase
    end
  end
endmodule // ip_address_source_select

// ### include/ip_source_consts.vh
`ifndef IP_SOURCE_CONSTS_VH
`define IP_SOURCE_CONSTS_VH

// switch bank bit positions (bit n is switch n)
`define SW_MODE_BIT      9
`define SW_BYTE_MSB      8
`define SW_BYTE_LSB      1
`define SW_PAT_MSB       4
// mode codes reported on mode_out
`define MODE_DEFAULT     3'h0
`define MODE_DIRECT      3'h1
`define MODE_DYN_SERVER  3'h2
`define MODE_BOOT_SERVER 3'h3
`define MODE_STORED      3'h4
`define MODE_ONE_TIME    3'h5
`define MODE_ERROR       3'h6
// switch 1..4 patterns with switch 9 on
`define PAT_DYN_SERVER   4'h1
`define PAT_BOOT_SERVER  4'h2
`define PAT_STORED       4'h4
`define PAT_ONE_TIME     4'h8
// default address set
`define DEF_IP           32'hC0A801FE
`define DEF_MASK         32'hFFFFFF00
`define DEF_GW           32'hC0A80101
// direct byte limits
`define LAST_BYTE_MIN    8'h01
`define LAST_BYTE_MAX    8'hFE
// upper three address bytes and power-up values of the address words
`define IP_HI_LSB        8
`define RST_WORD         32'h00000000
`define RST_BYTE         8'h00

`endif

// ### src/mode_decode.v
`timescale 1ns/1ps
`include "ip_source_consts.vh"

module mode_decode (
  input  wire [9:0] sw_in,
  output reg  [2:0] mode_out
);
  always @* begin
    if (!sw_in[`SW_MODE_BIT]) begin
      if (sw_in[`SW_BYTE_MSB:`SW_BYTE_LSB] == 8'h00)
        mode_out = `MODE_DEFAULT;
      else
        mode_out = `MODE_DIRECT;
    end else begin
      // switches 5..8 and switch 0 are not looked at here
      case (sw_in[`SW_PAT_MSB:`SW_BYTE_LSB])
        `PAT_DYN_SERVER:  mode_out = `MODE_DYN_SERVER;
        `PAT_BOOT_SERVER: mode_out = `MODE_BOOT_SERVER;
        `PAT_STORED:      mode_out = `MODE_STORED;
        `PAT_ONE_TIME:    mode_out = `MODE_ONE_TIME;
        default:          mode_out = `MODE_ERROR;
      endcase
    end
  end
endmodule // mode_decode

// ### verif/addr_sel_chk.sv
`timescale 1ns/1ps
`include "ip_source_consts.vh"

module addr_sel_chk (
  input wire logic        core_clk_in, nrst_in, srv_req_out, srv_rsp_in, nv_wr_out,
  input wire logic        nv_flag_wr_out, nv_flag_val_out, addr_valid_out, cfg_err_out, done_out,
  input wire logic [2:0]  mode_out,
  input wire logic [31:0] srv_ip_in, ip_out, mask_out, gw_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_req_held: assert property (srv_req_out && !srv_rsp_in |=> srv_req_out)
    else $error("server request dropped early");
  a_srv_result: assert property (srv_req_out && srv_rsp_in |=> ip_out == $past(srv_ip_in))
    else $error("server address not taken");
  a_store_then_flag: assert property (srv_req_out && srv_rsp_in && mode_out == `MODE_ONE_TIME
    |=> nv_wr_out ##1 (nv_flag_wr_out && nv_flag_val_out)) else $error("store or flag missing");
  a_flag_clear: assert property (nv_flag_wr_out && mode_out != `MODE_ONE_TIME
    |-> !nv_flag_val_out) else $error("flag not cleared");
  a_default_set: assert property (mode_out == `MODE_DEFAULT && done_out |-> addr_valid_out
    && ip_out == `DEF_IP && mask_out == `DEF_MASK && gw_out == `DEF_GW) else $error("bad default");
  a_error_noaddr: assert property (mode_out == `MODE_ERROR && done_out
    |-> !addr_valid_out && cfg_err_out) else $error("error mode took an address");
  a_direct_range: assert property (mode_out == `MODE_DIRECT && done_out
    |-> addr_valid_out == (ip_out[7:0] != 8'h00 && ip_out[7:0] != 8'hFF)) else $error("bad byte");
  a_result_frozen: assert property (done_out |=> done_out && $stable(ip_out)
    && $stable(mode_out)) else $error("result changed after power-up");
  a_stored_noserver: assert property (mode_out == `MODE_STORED |-> !srv_req_out)
    else $error("stored mode asked the server");
endmodule // addr_sel_chk

bind ip_address_source_select addr_sel_chk u_chk (.*);

// ### verif/addr_partner_model.sv
`timescale 1ns/1ps

module addr_partner_model (
  input  wire logic        clk_in, rd_in, wr_in, fwr_in, fval_in, req_in,
  input  wire logic [31:0] wip_in, wmk_in, wgw_in,
  output logic             ack_out = 1'b0,
  output logic             rsp_out = 1'b0,
  output logic             flag_out,
  output logic [31:0]      ip_out, mk_out, gw_out, sip_out, smk_out, sgw_out
);
  // nonvolatile contents survive the power-up reset, so no reset here
  logic [31:0] ip_reg = 32'h0A000105, mk_reg = 32'hFFFF0000, gw_reg = 32'h0A000001;
  logic        flag_reg = 1'b0;
  logic [3:0]  wait_reg = 4'h0;
  logic [7:0]  lease_reg = 8'h20;
  // lines read back inverted outside the answer cycle
  assign ip_out = ack_out ? ip_reg : ~ip_reg;
  assign mk_out = ack_out ? mk_reg : ~mk_reg;
  assign gw_out = ack_out ? gw_reg : ~gw_reg;
  assign flag_out = ack_out ? flag_reg : ~flag_reg;
  assign sip_out = rsp_out ? {24'h0A0B0C, lease_reg} : ~{24'h0A0B0C, lease_reg};
  assign smk_out = rsp_out ? 32'hFFFFFF00 : 32'h000000FF;
  assign sgw_out = rsp_out ? 32'h0A0B0C01 : 32'hF5F4F3FE;
  always @(posedge clk_in) begin
    ack_out <= rd_in;
    rsp_out <= req_in && !rsp_out && wait_reg == 4'h5;
    wait_reg <= (req_in && !rsp_out) ? wait_reg + 4'h1 : 4'h0;
    if (rsp_out)
      lease_reg <= lease_reg + 8'h01;
    if (wr_in) begin
      ip_reg <= wip_in;
      mk_reg <= wmk_in;
      gw_reg <= wgw_in;
    end
    if (fwr_in)
      flag_reg <= fval_in;
  end
endmodule // addr_partner_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "ip_source_consts.vh"

module tb_top;
  localparam logic [31:0] SM = 32'hFFFFFF00, SG = 32'h0A0B0C01;
  logic       core_clk_in = 1'b0, nrst_in = 1'b0;
  logic [9:0] sw_in = 10'h000;
  wire        rd, wr, fwr, fval, ack, rsp, flag, req, valid, err, done;
  wire [31:0] wip, wmk, wgw, nip, nmk, ngw, sip, smk, sgw, ip, mk, gw;
  wire [2:0]  mode;
  int         errors = 0, comparisons = 0, cycles = 0, rsps = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (rsp) rsps <= rsps + 1;
  ip_address_source_select DUT (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .sw_in(sw_in),
    .nv_rd_out(rd), .nv_wr_out(wr), .nv_wr_ip_out(wip), .nv_wr_mask_out(wmk),
    .nv_wr_gw_out(wgw), .nv_flag_wr_out(fwr), .nv_flag_val_out(fval), .nv_ack_in(ack),
    .nv_ip_in(nip), .nv_mask_in(nmk), .nv_gw_in(ngw), .nv_flag_in(flag), .srv_req_out(req),
    .srv_rsp_in(rsp), .srv_ip_in(sip), .srv_mask_in(smk), .srv_gw_in(sgw), .mode_out(mode),
    .ip_out(ip), .mask_out(mk), .gw_out(gw), .addr_valid_out(valid), .cfg_err_out(err),
    .done_out(done));
  addr_partner_model far (.clk_in(core_clk_in), .rd_in(rd), .wr_in(wr), .fwr_in(fwr),
    .fval_in(fval), .req_in(req), .wip_in(wip), .wmk_in(wmk), .wgw_in(wgw), .ack_out(ack),
    .rsp_out(rsp), .flag_out(flag), .ip_out(nip), .mk_out(nmk), .gw_out(ngw), .sip_out(sip),
    .smk_out(smk), .sgw_out(sgw));
  task check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // switches flip after sampling to show they are not read again
  task power_up(input logic [9:0] sw);
    int n;
    nrst_in = 1'b0;
    sw_in = sw;
    repeat (10) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    sw_in = ~sw;
    for (n = 0; n < 60 && done !== 1'b1; n++) @(negedge core_clk_in);
  endtask
  task result(input logic [2:0] m, input logic [31:0] i, k, g, input logic [1:0] ve);
    check(done, 1'b1);
    check({mode, valid, err}, {m, ve});
    check(ip, i);
    check(mk, k);
    check(gw, g);
  endtask
  task t_direct;
    power_up(10'h001);
    result(`MODE_DEFAULT, `DEF_IP, `DEF_MASK, `DEF_GW, 2'b10);
    power_up(10'h025);
    result(`MODE_DIRECT, 32'h0A000112, 32'hFFFF0000, 32'h0A000001, 2'b10);
    power_up(10'h1FC);
    check({ip[7:0], valid, err}, 10'h3FA);
    power_up(10'h1FE);
    check({ip[7:0], valid, err}, 10'h3FD);
    $display("direct and default test done");
  endtask
  task t_one_time;
    int n;
    power_up(10'h208);
    result(`MODE_STORED, 32'h0A000105, 32'hFFFF0000, 32'h0A000001, 2'b10);
    power_up(10'h3F0);
    result(`MODE_ONE_TIME, 32'h0A0B0C20, SM, SG, 2'b10);
    n = rsps;
    power_up(10'h210);
    check(rsps - n, 0);
    result(`MODE_ONE_TIME, 32'h0A0B0C20, SM, SG, 2'b10);
    power_up(10'h202);
    result(`MODE_DYN_SERVER, 32'h0A0B0C21, SM, SG, 2'b10);
    power_up(10'h210);
    result(`MODE_ONE_TIME, 32'h0A0B0C22, SM, SG, 2'b10);
    power_up(10'h204);
    result(`MODE_BOOT_SERVER, 32'h0A0B0C23, SM, SG, 2'b10);
    $display("server modes test done");
  endtask
  task t_error;
    power_up(10'h218);
    check({mode, valid, err}, {`MODE_ERROR, 2'b01});
    power_up(10'h3E0);
    check({mode, valid, err}, {`MODE_ERROR, 2'b01});
    $display("error test done");
  endtask
  task stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end
  initial begin
    t_direct();
    t_one_time();
    t_error();
    stop_test();
  end
endmodule // tb_top
